// File: rtl/djc_pkg.sv
// Purpose: constants for the drive i/o test and jog control block
// Assumes: 100 MHz core clock, 32-bit register port
// Notes:   register offsets are byte addresses, one word each
package djc_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ        = 100000000;
  localparam int unsigned DEBOUNCE_MS   = 10;
  localparam int unsigned DEBOUNCE_CYC  = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned DB_W          = 20;

  // sizes
  localparam int unsigned N_DI   = 8;
  localparam int unsigned N_DO   = 5;
  localparam int unsigned N_KEY  = 5;
  localparam int unsigned N_LIM  = 3;
  localparam int unsigned LIM_DI = 5;

  // key positions in the debounced key vector
  localparam int unsigned KEY_UP    = 0;
  localparam int unsigned KEY_DOWN  = 1;
  localparam int unsigned KEY_SHIFT = 2;
  localparam int unsigned KEY_SET   = 3;
  localparam int unsigned KEY_MODE  = 4;

  // register offsets
  localparam logic [7:0] OFS_FUNC_SEL    = 8'h00;
  localparam logic [7:0] OFS_FORCE_MASK  = 8'h04;
  localparam logic [7:0] OFS_IN_VIEW     = 8'h08;
  localparam logic [7:0] OFS_OUT_VIEW    = 8'h0C;
  localparam logic [7:0] OFS_JOG_SPEED   = 8'h10;
  localparam logic [7:0] OFS_IN_ASSIGN   = 8'h14;
  localparam logic [7:0] OFS_OUT_ASSIGN0 = 8'h18;

  // function-select codes and reset values
  localparam logic [15:0] FSEL_FORCE     = 16'h0196;
  localparam logic [15:0] FSEL_NORMAL    = 16'h0190;
  localparam logic [15:0] FSEL_RST       = 16'h0000;
  localparam logic [7:0]  MASK_RST       = 8'h00;
  localparam logic [15:0] JOG_SPEED_RST  = 16'h0014;
  localparam logic [15:0] JOG_SPEED_MAX  = 16'h1388;

  // input function codes
  localparam logic [7:0] IN_FN_OFF  = 8'h00;
  localparam logic [7:0] IN_FN_ESTOP = 8'h15;
  localparam logic [7:0] IN_FN_REV   = 8'h16;
  localparam logic [7:0] IN_FN_FWD   = 8'h17;
  localparam logic [23:0] IN_ASSIGN_RST = {IN_FN_ESTOP, IN_FN_FWD, IN_FN_REV};

  // output assign: [4] active high, [3:0] source index, zero = off
  localparam logic [4:0] OUT_ASSIGN_RST = 5'h10;

  typedef enum logic [1:0] {
    DJC_JOG_NAME,
    DJC_JOG_EDIT,
    DJC_JOG_RUN
  } djc_jog_state_e;
endpackage

// File: rtl/djc_io_jog.sv
// Purpose: forced outputs, i/o status views and keypad jog of a servo drive
// Assumes: all inputs synchronous to core_clk_i; keys are active high
// Notes:   read data stands one cycle after the read strobe, zero otherwise
module djc_io_jog
  import djc_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  // register port
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  // drive side
  input  wire logic              drive_enable_i,
  input  wire logic [N_DI-1:0]   din_i,
  input  wire logic [15:0]       out_func_src_i,
  output logic      [N_DO-1:0]   dout_o,
  output logic                   reverse_inhibit_limit_o,
  output logic                   forward_inhibit_limit_o,
  output logic                   emergency_stop_o,
  // keypad
  input  wire logic              key_up_i,
  input  wire logic              key_down_i,
  input  wire logic              key_shift_i,
  input  wire logic              key_set_i,
  input  wire logic              key_mode_i,
  // display and jog
  output djc_jog_state_e         disp_mode_o,
  output logic      [1:0]        edit_digit_o,
  output logic      [15:0]       jog_speed_o,
  output logic                   jog_ccw_o,
  output logic                   jog_cw_o
);

  logic [15:0]      func_sel;
  logic [7:0]       force_mask;
  logic [23:0]      in_assign;
  logic [4:0]       out_assign [N_DO];
  logic [N_KEY-1:0] key_raw;
  logic [N_KEY-1:0] key_lvl;
  logic [N_KEY-1:0] key_prev;
  logic [N_KEY-1:0] key_press;
  logic [N_DO-1:0]  normal_out;
  logic             force_act;
  logic [15:0]      step;
  logic [31:0]      next_rdata;
  logic             next_rev;
  logic             next_fwd;
  logic             next_estop;

  assign key_raw = {key_mode_i, key_set_i, key_shift_i, key_down_i, key_up_i};

  // ---------------- registers written by software ----------------
  // the mask is plain flops, so nothing survives a power cycle
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      func_sel   <= FSEL_RST;
      force_mask <= MASK_RST;
      in_assign  <= IN_ASSIGN_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_FUNC_SEL:   func_sel   <= reg_wdata_i[15:0];
        OFS_FORCE_MASK: force_mask <= reg_wdata_i[7:0];
        OFS_IN_ASSIGN:  in_assign  <= reg_wdata_i[23:0];
        default: ;
      endcase
    end
  end

  // return code or any other value leaves forcing off
  assign force_act = (func_sel == FSEL_FORCE) && !drive_enable_i;

  genvar gi;
  generate
    for (gi = 0; gi < N_DO; gi++) begin : g_do
      always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          out_assign[gi] <= OUT_ASSIGN_RST | 5'(gi + 1);
        end else if (reg_wr_i && reg_addr_i == OFS_OUT_ASSIGN0 + 8'(4 * gi)) begin
          out_assign[gi] <= reg_wdata_i[4:0];
        end
      end
      // source index zero means the output has no function
      assign normal_out[gi] = (out_assign[gi][3:0] == 4'h0) ? 1'b0 :
        (out_func_src_i[out_assign[gi][3:0]] ~^ out_assign[gi][4]);
    end
  endgenerate

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dout_o <= '0;
    end else if (force_act) begin
      dout_o <= force_mask[N_DO-1:0];
    end else begin
      dout_o <= normal_out;
    end
  end

  // ---------------- input functions on inputs six to eight ----------------
  always_comb begin
    next_rev   = 1'b0;
    next_fwd   = 1'b0;
    next_estop = 1'b0;
    for (int k = 0; k < N_LIM; k++) begin
      if (din_i[LIM_DI + k]) begin
        case (in_assign[8*k +: 8])
          IN_FN_REV:   next_rev   = 1'b1;
          IN_FN_FWD:   next_fwd   = 1'b1;
          IN_FN_ESTOP: next_estop = 1'b1;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reverse_inhibit_limit_o <= 1'b0;
      forward_inhibit_limit_o <= 1'b0;
      emergency_stop_o        <= 1'b0;
    end else begin
      reverse_inhibit_limit_o <= next_rev;
      forward_inhibit_limit_o <= next_fwd;
      emergency_stop_o        <= next_estop;
    end
  end

  // ---------------- register reads ----------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (reg_addr_i)
      OFS_FUNC_SEL:   next_rdata = {16'h0000, func_sel};
      OFS_FORCE_MASK: next_rdata = {24'h00_0000, force_mask};
      OFS_IN_VIEW:    next_rdata = {24'h00_0000, din_i};
      OFS_OUT_VIEW:   next_rdata = {27'h0, dout_o};
      OFS_JOG_SPEED:  next_rdata = {16'h0000, jog_speed_o};
      OFS_IN_ASSIGN:  next_rdata = {8'h00, in_assign};
      default: begin
        for (int k = 0; k < N_DO; k++) begin
          if (reg_addr_i == OFS_OUT_ASSIGN0 + 8'(4 * k)) begin
            next_rdata = {27'h0, out_assign[k]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= reg_rd_i ? next_rdata : 32'h0000_0000;
    end
  end

  // ---------------- key debounce ----------------
  // a long settle window trades key latency for immunity to contact bounce
  generate
    for (gi = 0; gi < N_KEY; gi++) begin : g_key
      logic [DB_W-1:0] cnt;
      always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cnt         <= '0;
          key_lvl[gi] <= 1'b0;
        end else if (key_raw[gi] == key_lvl[gi]) begin
          cnt <= '0;
        end else if (cnt == DB_W'(DEBOUNCE_CYCLES - 1)) begin
          cnt         <= '0;
          key_lvl[gi] <= key_raw[gi];
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      key_prev <= '0;
    end else begin
      key_prev <= key_lvl;
    end
  end

  assign key_press = key_lvl & ~key_prev;

  // ---------------- jog sequence ----------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      disp_mode_o <= DJC_JOG_NAME;
    end else begin
      case (disp_mode_o)
        DJC_JOG_NAME: if (key_press[KEY_SET]) disp_mode_o <= DJC_JOG_EDIT;
        DJC_JOG_EDIT: if (key_press[KEY_SET]) disp_mode_o <= DJC_JOG_RUN;
        DJC_JOG_RUN:  if (key_press[KEY_MODE]) disp_mode_o <= DJC_JOG_NAME;
        default:      disp_mode_o <= DJC_JOG_NAME;
      endcase
    end
  end

  // digit 0 is units; display blinks this digit while editing
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      edit_digit_o <= 2'h0;
    end else if (disp_mode_o != DJC_JOG_EDIT) begin
      edit_digit_o <= 2'h0;
    end else if (key_press[KEY_SHIFT]) begin
      edit_digit_o <= edit_digit_o + 2'h1;
    end
  end

  always_comb begin
    case (edit_digit_o)
      2'h0:    step = 16'h0001;
      2'h1:    step = 16'h000A;
      2'h2:    step = 16'h0064;
      default: step = 16'h03E8;
    endcase
  end

  // value saturates at the limits rather than wrapping
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      jog_speed_o <= JOG_SPEED_RST;
    end else if (reg_wr_i && reg_addr_i == OFS_JOG_SPEED) begin
      jog_speed_o <= (reg_wdata_i[15:0] > JOG_SPEED_MAX) ? JOG_SPEED_MAX : reg_wdata_i[15:0];
    end else if (disp_mode_o == DJC_JOG_EDIT) begin
      if (key_press[KEY_UP] && !key_press[KEY_DOWN]) begin
        jog_speed_o <= (jog_speed_o > JOG_SPEED_MAX - step) ?
                       JOG_SPEED_MAX : jog_speed_o + step;
      end else if (key_press[KEY_DOWN] && !key_press[KEY_UP]) begin
        jog_speed_o <= (jog_speed_o < step) ? 16'h0000 : jog_speed_o - step;
      end
    end
  end

  // both arrows together give no motion
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      jog_ccw_o <= 1'b0;
      jog_cw_o  <= 1'b0;
    end else begin
      jog_ccw_o <= (disp_mode_o == DJC_JOG_RUN) && drive_enable_i &&
                   key_lvl[KEY_UP] && !key_lvl[KEY_DOWN];
      jog_cw_o  <= (disp_mode_o == DJC_JOG_RUN) && drive_enable_i &&
                   key_lvl[KEY_DOWN] && !key_lvl[KEY_UP];
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  AST_FORCE_DRIVES: assert property (
    (func_sel == FSEL_FORCE && !drive_enable_i) |=> dout_o == $past(force_mask[N_DO-1:0]))
    else $error("forced mask not on outputs");
  AST_RETURN_CODE: assert property (
    (reg_wr_i && reg_addr_i == OFS_FUNC_SEL && reg_wdata_i[15:0] == FSEL_NORMAL)
    |=> !force_act ##1 dout_o == $past(normal_out))
    else $error("return code did not restore outputs");
  AST_ENABLED_NORMAL: assert property (
    drive_enable_i |=> dout_o == $past(normal_out))
    else $error("mask acted while drive enabled");
  AST_IN_VIEW: assert property (
    (reg_rd_i && reg_addr_i == OFS_IN_VIEW) |=> reg_rdata_o == {24'h00_0000, $past(din_i)})
    else $error("input view mismatch");
  AST_OUT_VIEW: assert property (
    (reg_rd_i && reg_addr_i == OFS_OUT_VIEW) |=> reg_rdata_o[N_DO-1:0] == $past(dout_o))
    else $error("output view mismatch");
  AST_JOG_GATED: assert property (
    (jog_ccw_o || jog_cw_o) |-> $past(drive_enable_i) && $past(disp_mode_o) == DJC_JOG_RUN)
    else $error("jog motion without enable");
  AST_JOG_DIR: assert property (
    jog_ccw_o |-> !jog_cw_o && $past(key_lvl[KEY_UP]))
    else $error("jog direction wrong");
  AST_SET_ENTERS: assert property (
    (disp_mode_o == DJC_JOG_EDIT && key_press[KEY_SET]) |=> disp_mode_o == DJC_JOG_RUN)
    else $error("set did not enter jog");
  AST_MODE_EXITS: assert property (
    (disp_mode_o == DJC_JOG_RUN && key_press[KEY_MODE])
    |=> disp_mode_o == DJC_JOG_NAME ##1 !jog_ccw_o && !jog_cw_o)
    else $error("mode did not leave jog");

  COV_FORCE: cover property (force_act ##1 dout_o != normal_out);
  COV_JOG_CCW: cover property (jog_ccw_o [*3]);
  COV_EDIT_UP: cover property (disp_mode_o == DJC_JOG_EDIT && key_press[KEY_UP]);
endmodule

// File: dv/djc_keypad_model.sv
// Purpose: keypad and digital input wiring at the far side of the jog block
// Assumes: keys active high, every level changes just after a rising edge
// Notes:   short taps stand in for contact bounce
module djc_keypad_model (
  // clock
  input  wire logic       clk_i,
  // keypad and wiring
  output logic [4:0]      key_o,
  output logic [7:0]      din_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    key_o = 5'h00;
    din_o = 8'h00;
  end

  // release waits long enough for the debouncer to settle both ways
  task automatic tap(input int k, input int cyc);
    @(posedge clk_i) key_o[k] <= 1'b1;
    repeat (cyc) @(posedge clk_i);
    key_o[k] <= 1'b0;
    repeat (12) @(negedge clk_i);
  endtask

  task automatic hold(input int k, input logic lv);
    @(posedge clk_i) key_o[k] <= lv;
    repeat (10) @(negedge clk_i);
  endtask

  task automatic set_in(input logic [7:0] v);
    @(posedge clk_i) din_o <= v;
    repeat (3) @(negedge clk_i);
  endtask
endmodule

// File: dv/tb_drive_io_test_and_jog_control.sv
// Purpose: self-checking bench for forced outputs, status views and jog
// Assumes: debounce shortened to 4 cycles
// Notes:   outputs are sampled on the falling edge
module tb_drive_io_test_and_jog_control import djc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic           clk        = 1'b0;
  logic           resetn     = 1'b0;
  logic           wr         = 1'b0;
  logic           rd         = 1'b0;
  logic           en         = 1'b0;
  logic [7:0]     addr       = 8'h00;
  logic [31:0]    wdata      = 32'h0000_0000;
  logic [15:0]    src        = 16'h0000;
  logic [31:0]    rdata;
  logic [31:0]    d;
  logic [15:0]    speed;
  logic [4:0]     dout;
  logic [4:0]     key;
  logic [7:0]     din;
  logic           rev;
  logic           fwd;
  logic           estop;
  logic           ccw;
  logic           cw;
  logic [1:0]     digit;
  djc_jog_state_e disp;
  int             num_errors = 0;
  int             tests_run  = 0;

  always #5 clk = ~clk;

  djc_keypad_model kp (.clk_i(clk), .key_o(key), .din_o(din));

  djc_io_jog #(.DEBOUNCE_CYCLES(4)) dut (
    .core_clk_i(clk), .resetn_i(resetn), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .drive_enable_i(en),
    .din_i(din), .out_func_src_i(src), .dout_o(dout),
    .reverse_inhibit_limit_o(rev), .forward_inhibit_limit_o(fwd),
    .emergency_stop_o(estop), .key_up_i(key[KEY_UP]), .key_down_i(key[KEY_DOWN]),
    .key_shift_i(key[KEY_SHIFT]), .key_set_i(key[KEY_SET]), .key_mode_i(key[KEY_MODE]),
    .disp_mode_o(disp), .edit_digit_o(digit), .jog_speed_o(speed),
    .jog_ccw_o(ccw), .jog_cw_o(cw));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) begin
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
    end
    @(posedge clk) wr <= 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk) begin
      addr <= a;
      rd <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) v = rdata;
  endtask

  task automatic set_en(input logic v);
    @(posedge clk) en <= v;
    repeat (3) @(negedge clk);
  endtask

  task automatic t_reset();
    @(negedge clk);
    chk("dout_rst", 32'h00, dout);
    chk("motion_rst", 32'h0, {ccw, cw});
    chk("limits_rst", 32'h0, {rev, fwd, estop});
    chk("digit_rst", 32'h0, digit);
    chk("disp", DJC_JOG_NAME, disp);
    rd_reg(OFS_FUNC_SEL, d);
    chk("func_sel", {16'h0000, FSEL_RST}, d);
    @(negedge clk);
    chk("rdata_idle", 32'h0, rdata);
    rd_reg(OFS_FORCE_MASK, d);
    chk("mask", {24'h00_0000, MASK_RST}, d);
    rd_reg(OFS_JOG_SPEED, d);
    chk("jog_speed", {16'h0000, JOG_SPEED_RST}, d);
    rd_reg(OFS_IN_ASSIGN, d);
    chk("in_assign", {8'h00, IN_ASSIGN_RST}, d);
    rd_reg(OFS_OUT_ASSIGN0, d);
    chk("out_assign", 32'h11, d);
    rd_reg(8'hFC, d);
    chk("unmapped", 32'h0, d);
    wr_reg(OFS_JOG_SPEED, 32'h0000_FFFF);
    rd_reg(OFS_JOG_SPEED, d);
    chk("speed_clamp", {16'h0000, JOG_SPEED_MAX}, d);
    wr_reg(OFS_JOG_SPEED, {16'h0000, JOG_SPEED_RST});
    $display("test reset done");
  endtask

  task automatic t_normal();
    @(posedge clk) src <= 16'h0014;
    repeat (3) @(negedge clk);
    chk("dout", 32'h0A, dout);
    rd_reg(OFS_OUT_VIEW, d);
    chk("out_view", 32'h0A, d);
    wr_reg(OFS_OUT_ASSIGN0, 32'h01);
    chk("dout_inv", 32'h0B, dout);
    wr_reg(OFS_OUT_ASSIGN0, 32'h00);
    chk("dout_none", 32'h0A, dout);
    wr_reg(OFS_OUT_ASSIGN0, 32'h11);
    $display("test normal done");
  endtask

  task automatic t_force();
    wr_reg(OFS_FORCE_MASK, 32'h05);
    chk("dout_pre", 32'h0A, dout);
    wr_reg(OFS_FUNC_SEL, 32'h0000_0195);
    chk("dout_other", 32'h0A, dout);
    wr_reg(OFS_FUNC_SEL, {16'h0000, FSEL_FORCE});
    chk("dout_5", 32'h05, dout);
    wr_reg(OFS_FORCE_MASK, 32'h02);
    chk("dout_2", 32'h02, dout);
    rd_reg(OFS_OUT_VIEW, d);
    chk("out_view", 32'h02, d);
    set_en(1'b1);
    chk("dout_on", 32'h0A, dout);
    set_en(1'b0);
    chk("dout_off", 32'h02, dout);
    wr_reg(OFS_FUNC_SEL, {16'h0000, FSEL_NORMAL});
    chk("dout_ret", 32'h0A, dout);
    wr_reg(OFS_FUNC_SEL, {16'h0000, FSEL_FORCE});
    chk("dout_again", 32'h02, dout);
    @(posedge clk) resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(negedge clk);
    chk("dout_pwr", 32'h0A, dout);
    rd_reg(OFS_FORCE_MASK, d);
    chk("mask_pwr", 32'h0, d);
    rd_reg(OFS_FUNC_SEL, d);
    chk("fsel_pwr", {16'h0000, FSEL_RST}, d);
    $display("test force done");
  endtask

  task automatic t_views();
    kp.set_in(8'hE1);
    rd_reg(OFS_IN_VIEW, d);
    chk("in_view", 32'hE1, d);
    chk("limits", 32'h7, {rev, fwd, estop});
    kp.set_in(8'h20);
    chk("limits_rev", 32'h4, {rev, fwd, estop});
    wr_reg(OFS_IN_VIEW, 32'h0);
    rd_reg(OFS_IN_VIEW, d);
    chk("in_view_ro", 32'h20, d);
    wr_reg(OFS_IN_ASSIGN, 32'h0);
    kp.set_in(8'hE0);
    chk("limits_off", 32'h0, {rev, fwd, estop});
    wr_reg(OFS_IN_ASSIGN, {24'h00_0000, IN_FN_ESTOP});
    kp.set_in(8'h20);
    chk("limits_move", 32'h1, {rev, fwd, estop});
    wr_reg(OFS_IN_ASSIGN, {8'h00, IN_ASSIGN_RST});
    kp.set_in(8'h00);
    $display("test views done");
  endtask

  task automatic t_jog();
    set_en(1'b1);
    kp.tap(KEY_SET, 8);
    chk("edit", DJC_JOG_EDIT, disp);
    chk("speed", 32'h14, speed);
    kp.tap(KEY_UP, 8);
    chk("up", 32'h15, speed);
    kp.tap(KEY_SHIFT, 8);
    chk("digit", 32'h1, digit);
    kp.tap(KEY_UP, 8);
    chk("up10", 32'h1F, speed);
    kp.tap(KEY_DOWN, 8);
    chk("down10", 32'h15, speed);
    kp.tap(KEY_UP, 2);
    chk("bounce", 32'h15, speed);
    kp.tap(KEY_SET, 8);
    chk("run", DJC_JOG_RUN, disp);
    chk("speed_kept", 32'h15, speed);
    kp.hold(KEY_UP, 1'b1);
    chk("ccw", 32'h2, {ccw, cw});
    kp.hold(KEY_UP, 1'b0);
    chk("stop", 32'h0, {ccw, cw});
    kp.hold(KEY_DOWN, 1'b1);
    chk("cw", 32'h1, {ccw, cw});
    chk("speed_run", 32'h15, speed);
    set_en(1'b0);
    chk("no_enable", 32'h0, {ccw, cw});
    kp.hold(KEY_DOWN, 1'b0);
    kp.hold(KEY_UP, 1'b1);
    chk("no_enable_up", 32'h0, {ccw, cw});
    kp.hold(KEY_UP, 1'b0);
    kp.tap(KEY_MODE, 8);
    chk("name", DJC_JOG_NAME, disp);
    kp.tap(KEY_SET, 8);
    chk("reedit", DJC_JOG_EDIT, disp);
    chk("digit_home", 32'h0, digit);
    $display("test jog done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // whole sequence needs a few hundred cycles
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_normal();
    t_force();
    t_views();
    t_jog();
    complete_run();
  end
endmodule
